// ==== rtl/sdis_pkg.sv ====
package sdis_pkg;

   // ***********************************************
   // Register map and reset values
   // ***********************************************
   localparam logic [3:0]  SDIS_ADDR_STATUS   = 4'h0;
   localparam logic [3:0]  SDIS_ADDR_MASK     = 4'h1;
   localparam logic [3:0]  SDIS_ADDR_IDENT    = 4'h2;
   localparam logic [3:0]  SDIS_ADDR_ENABLE   = 4'h3;
   localparam logic [3:0]  SDIS_ADDR_EN_ARM   = 4'h4;
   localparam logic [31:0] SDIS_RST_STATUS    = 32'h00000000;
   localparam logic [31:0] SDIS_RST_MASK      = 32'hFFFFFFFF;
   localparam logic [31:0] SDIS_RST_IDENT     = 32'h00000000;
   localparam logic [31:0] SDIS_RST_ENABLE    = 32'h00000000;

   // ***********************************************
   // Shared bit positions of the interrupt group
   // ***********************************************
   localparam int SDIS_BIT_AUDPWR_B = 29;
   localparam int SDIS_BIT_SIDEBAND_B = 25;
   localparam int SDIS_BIT_DIGATT_B = 21;
   localparam int SDIS_BIT_ANALOG  = 19;
   localparam int SDIS_BIT_SERBUS  = 17;
   // Bits that have a source attached; all others read zero
   localparam logic [31:0] SDIS_IMPL_BITS = 32'hEEEA0000;

   // Register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sdis_bus_s;

   // Raw event sources, each vector is ports D,C,B in bits 2,1,0
   typedef struct packed {
      logic [2:0] audio_pwr_pulse;
      logic [2:0] sideband_done_pulse;
      logic [2:0] digital_attach_line;
      logic [2:0] digital_attach_enable;
      logic [2:0] digital_attach_detect;
      logic       analog_blue_detect;
      logic       analog_green_detect;
      logic       serial_bus_pulse;
   } sdis_src_s;

endpackage

// ==== rtl/sdis_irq.sv ====
// How it works
// - Reserved bits ignore writes, read zero
// - Read-only bits unaffected by writes
// - Sticky bits set by event, cleared writing one
// - Double-buffered enable: stage one, stage two
// - Enable transfer waits for arm register write
// - Outgoing interrupt is OR of identity bits
// - North side latches only rising edges
// - All four registers share bit positions
// - Bits 31..29 audio power pulses D,C,B
// - Bits 27..25 sideband done pulses D,C,B
// - Bits 23..21 attach level when enabled
// - Attach identity set on short/long detect
// - Bit 19 is blue OR green detect
// - Analog identity set on both edges
// - Bit 17 serial bus unmasked event pulse
// - Status is live state, resets zero
// - Mask one blocks identity, resets all ones
// - Identity queues one further occurrence
// - Enable gates only the outgoing interrupt
//
// Decided for this implementation: the strobed register port and the register addresses.
module sdis_irq
   import sdis_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic [2:0]  i_audio_pwr_pulse,
   input  wire logic [2:0]  i_sideband_done_pulse,
   input  wire logic [2:0]  i_digital_attach_line,
   input  wire logic [2:0]  i_digital_attach_enable,
   input  wire logic [2:0]  i_digital_attach_detect,
   input  wire logic        i_analog_blue_detect,
   input  wire logic        i_analog_green_detect,
   input  wire logic        i_serial_bus_pulse,
   output logic             o_south_irq,
   output logic             o_north_south_event
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [31:0] rdata;
      logic [31:0] status;
      logic [31:0] mask;
      logic [31:0] ident;
      logic [31:0] queued;
      logic [31:0] en_stage1;
      logic [31:0] en_stage2;
      logic        en_armed;
      logic [31:0] prev_status;
      logic        irq;
      logic        irq_prev;
      logic        north_event;
   } sdis_state_s;

   sdis_state_s state_ff;
   sdis_state_s nxt_state;
   sdis_bus_s   bus;
   sdis_src_s   src;

   // Pack ports into carriers
   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign src = '{audio_pwr_pulse: i_audio_pwr_pulse, sideband_done_pulse: i_sideband_done_pulse,
                  digital_attach_line: i_digital_attach_line, digital_attach_enable: i_digital_attach_enable,
                  digital_attach_detect: i_digital_attach_detect, analog_blue_detect: i_analog_blue_detect,
                  analog_green_detect: i_analog_green_detect, serial_bus_pulse: i_serial_bus_pulse};

   // Register decode, used for writes; reads decode the address in a case
   function automatic logic hit(input sdis_bus_s b, input logic [3:0] a);
      hit = (b.addr == a);
   endfunction

   // ***********************************************
   // Live status and set requests
   // ***********************************************
   logic [31:0] live;
   logic [31:0] set_req;
   logic [31:0] clr_req;
   logic [31:0] masked_set;

   always_comb begin
      live    = '0;
      set_req = '0;
      live[SDIS_BIT_AUDPWR_B +: 3]   = src.audio_pwr_pulse;
      live[SDIS_BIT_SIDEBAND_B +: 3] = src.sideband_done_pulse;
      live[SDIS_BIT_DIGATT_B +: 3]   = src.digital_attach_line & src.digital_attach_enable;
      live[SDIS_BIT_ANALOG]          = src.analog_blue_detect | src.analog_green_detect;
      live[SDIS_BIT_SERBUS]          = src.serial_bus_pulse;
      // Pulses are taken as one request per high cycle
      set_req[SDIS_BIT_AUDPWR_B +: 3]   = src.audio_pwr_pulse;
      set_req[SDIS_BIT_SIDEBAND_B +: 3] = src.sideband_done_pulse;
      set_req[SDIS_BIT_DIGATT_B +: 3]   = src.digital_attach_detect;
      // Analog requests a set on either edge of combined detect
      set_req[SDIS_BIT_ANALOG] = live[SDIS_BIT_ANALOG] ^ state_ff.prev_status[SDIS_BIT_ANALOG];
      set_req[SDIS_BIT_SERBUS] = src.serial_bus_pulse;
   end

   // Unimplemented positions never set; mask blocks identity
   assign masked_set = set_req & ~state_ff.mask & SDIS_IMPL_BITS;
   assign clr_req    = (bus.wr && hit(bus, SDIS_ADDR_IDENT)) ? bus.wdata : 32'h00000000;

   // ***********************************************
   // Next-state logic
   // ***********************************************
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.status = live & SDIS_IMPL_BITS;
      nxt_state.prev_status = live;
      // Sticky identity with one queued occurrence; clear pops the queue
      for (int i = 0; i < 32; i++) begin
         if (clr_req[i]) begin
            // Queued copy returns next cycle, so the line dips low
            nxt_state.ident[i]  = masked_set[i];
            nxt_state.queued[i] = state_ff.queued[i] & masked_set[i];
            if (state_ff.queued[i] && !masked_set[i]) begin
               nxt_state.queued[i] = 1'b0;
            end
         end else if (masked_set[i]) begin
            if (state_ff.ident[i]) begin
               nxt_state.queued[i] = 1'b1;
            end
            nxt_state.ident[i] = 1'b1;
         end
         // Pending queued occurrence re-raises after the dip
         if (!state_ff.ident[i] && state_ff.queued[i]) begin
            nxt_state.ident[i]  = 1'b1;
            nxt_state.queued[i] = masked_set[i];
         end
      end
      // Clear with a queued copy dips low; a new event wins over the dip
      for (int i = 0; i < 32; i++) begin
         if (clr_req[i] && state_ff.queued[i]) begin
            nxt_state.ident[i]  = masked_set[i];
            nxt_state.queued[i] = 1'b1;
         end
      end
      // Enable keeps only implemented bits; mask holds reserved bits at one
      if (bus.wr && hit(bus, SDIS_ADDR_MASK)) begin
         nxt_state.mask = bus.wdata | ~SDIS_IMPL_BITS;
      end
      if (bus.wr && hit(bus, SDIS_ADDR_ENABLE)) begin
         nxt_state.en_stage1 = bus.wdata & SDIS_IMPL_BITS;
         nxt_state.en_armed  = 1'b1;
      end
      // Second stage loads only when the arm register is written
      if (bus.wr && hit(bus, SDIS_ADDR_EN_ARM) && state_ff.en_armed) begin
         nxt_state.en_stage2 = state_ff.en_stage1;
         nxt_state.en_armed  = 1'b0;
      end
      // Enable only gates the outgoing line, never the identity
      nxt_state.irq         = |(nxt_state.ident & state_ff.en_stage2);
      nxt_state.irq_prev    = state_ff.irq;
      nxt_state.north_event = state_ff.irq & ~state_ff.irq_prev;
      // Read data, one cycle after the strobe, zero otherwise
      nxt_state.rdata = 32'h00000000;
      if (bus.rd) begin
         unique case (bus.addr)
            SDIS_ADDR_STATUS: nxt_state.rdata = state_ff.status;
            SDIS_ADDR_MASK:   nxt_state.rdata = state_ff.mask & SDIS_IMPL_BITS;
            SDIS_ADDR_IDENT:  nxt_state.rdata = state_ff.ident;
            SDIS_ADDR_ENABLE: nxt_state.rdata = state_ff.en_stage1;
            SDIS_ADDR_EN_ARM: nxt_state.rdata = {31'h00000000, state_ff.en_armed};
            default:          nxt_state.rdata = 32'h00000000;
         endcase
      end
   end

   // ***********************************************
   // State register
   // ***********************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_ff <= '{rdata: 32'h00000000, status: SDIS_RST_STATUS, mask: SDIS_RST_MASK,
                       ident: SDIS_RST_IDENT, queued: 32'h00000000, en_stage1: SDIS_RST_ENABLE,
                       en_stage2: SDIS_RST_ENABLE, en_armed: 1'b0, prev_status: 32'h00000000,
                       irq: 1'b0, irq_prev: 1'b0, north_event: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_rdata             = state_ff.rdata;
   assign o_south_irq         = state_ff.irq;
   assign o_north_south_event = state_ff.north_event;

   // ***********************************************
   // Assertions
   // ***********************************************
   property p_mask_block;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_ff.mask[SDIS_BIT_SERBUS] && !state_ff.ident[SDIS_BIT_SERBUS] && !state_ff.queued[SDIS_BIT_SERBUS])
      |=> !state_ff.ident[SDIS_BIT_SERBUS];
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked source set identity");

   property p_set;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_serial_bus_pulse && !state_ff.mask[SDIS_BIT_SERBUS]) |=> state_ff.ident[SDIS_BIT_SERBUS];
   endproperty
   a_set: assert property (p_set) else $error("unmasked pulse lost");

   property p_reserved;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |-> ((state_ff.ident | state_ff.status | state_ff.en_stage2) & ~SDIS_IMPL_BITS) == 32'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_or;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> o_south_irq == |(state_ff.ident & $past(state_ff.en_stage2));
   endproperty
   a_or: assert property (p_or) else $error("interrupt not OR of identity");

   property p_edge;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_north_south_event |-> $past(o_south_irq) && !$past(o_south_irq, 2);
   endproperty
   a_edge: assert property (p_edge) else $error("north event without rising edge");

   property p_arm;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !(i_wr && i_addr == SDIS_ADDR_EN_ARM) |=> $stable(state_ff.en_stage2);
   endproperty
   a_arm: assert property (p_arm) else $error("enable moved without arm");

   property p_status;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> state_ff.status[SDIS_BIT_ANALOG] == $past(i_analog_blue_detect | i_analog_green_detect);
   endproperty
   a_status: assert property (p_status) else $error("analog status wrong");

   property p_rd;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_rd |=> o_rdata == 32'h0;
   endproperty
   a_rd: assert property (p_rd) else $error("read data outside read");

   // Source mapping, queue and gating checks
   property p_audio_status;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> state_ff.status[SDIS_BIT_AUDPWR_B +: 3] == $past(i_audio_pwr_pulse);
   endproperty
   a_audio_status: assert property (p_audio_status) else $error("audio power status misplaced");

   property p_sideband_status;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> state_ff.status[SDIS_BIT_SIDEBAND_B +: 3] == $past(i_sideband_done_pulse);
   endproperty
   a_sideband_status: assert property (p_sideband_status) else $error("sideband status misplaced");

   property p_attach_status;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1 |=> state_ff.status[SDIS_BIT_DIGATT_B +: 3] == $past(i_digital_attach_line & i_digital_attach_enable);
   endproperty
   a_attach_status: assert property (p_attach_status) else $error("attach status not gated");

   property p_attach_set;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_digital_attach_detect[0] && !state_ff.mask[SDIS_BIT_DIGATT_B]) |=> state_ff.ident[SDIS_BIT_DIGATT_B];
   endproperty
   a_attach_set: assert property (p_attach_set) else $error("attach detect lost");

   property p_analog_edge;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!state_ff.mask[SDIS_BIT_ANALOG] && $changed(i_analog_blue_detect | i_analog_green_detect))
      |=> state_ff.ident[SDIS_BIT_ANALOG];
   endproperty
   a_analog_edge: assert property (p_analog_edge) else $error("analog edge lost");

   property p_stage;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == SDIS_ADDR_ENABLE) |=> state_ff.en_stage1 == ($past(i_wdata) & SDIS_IMPL_BITS);
   endproperty
   a_stage: assert property (p_stage) else $error("enable write missed stage one");

   property p_rd_reserved;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr != SDIS_ADDR_EN_ARM) |=> (o_rdata & ~SDIS_IMPL_BITS) == 32'h00000000;
   endproperty
   a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bit read back");

   property p_dip;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == SDIS_ADDR_IDENT && i_wdata[SDIS_BIT_SERBUS] && state_ff.queued[SDIS_BIT_SERBUS]
       && !i_serial_bus_pulse) |=> !state_ff.ident[SDIS_BIT_SERBUS];
   endproperty
   a_dip: assert property (p_dip) else $error("queued clear did not dip");

   property p_reraise;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!state_ff.ident[SDIS_BIT_SERBUS] && state_ff.queued[SDIS_BIT_SERBUS]
       && !(i_wr && i_addr == SDIS_ADDR_IDENT && i_wdata[SDIS_BIT_SERBUS])) |=> state_ff.ident[SDIS_BIT_SERBUS];
   endproperty
   a_reraise: assert property (p_reraise) else $error("queued occurrence lost");

   property p_quiet;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_ff.en_stage2 == 32'h00000000) |=> !o_south_irq;
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt without enable");

   c_irq:    cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_south_irq));
   c_queue:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) |state_ff.queued);
   c_north:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_north_south_event);
   c_dip:    cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
                             $fell(state_ff.ident[SDIS_BIT_SERBUS]) && state_ff.queued[SDIS_BIT_SERBUS]);
   c_arm:    cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
                             i_wr && i_addr == SDIS_ADDR_EN_ARM && state_ff.en_armed);

endmodule

// ==== verification/sdis_north_model.sv ====
module sdis_north_model (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_south_irq,
   input  wire logic i_north_event,
   input  wire logic i_ack,
   output logic      o_latched_ff,
   output int        o_rise_cnt,
   output int        o_event_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic irq_ff;
   // ***************************************
   // North side event capture
   // ***************************************
   // Rises counted from the level itself, so a stuck or doubled event shows
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         irq_ff       <= 1'b0;
         o_latched_ff <= 1'b0;
         o_rise_cnt   <= 0;
         o_event_cnt  <= 0;
      end else begin
         irq_ff <= i_south_irq;
         if (i_south_irq && !irq_ff) o_rise_cnt <= o_rise_cnt + 1;
         if (i_north_event) o_event_cnt <= o_event_cnt + 1;
         if (i_north_event) o_latched_ff <= 1'b1;
         else if (i_ack) o_latched_ff <= 1'b0;
      end
   end
endmodule

// ==== verification/south_display_interrupt_sources_test.sv ====
module south_display_interrupt_sources_test
   import sdis_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************
   // Bench signals, clock and instances
   // ***************************************
   logic        i_sys_clk = 1'b0;
   logic        i_rst_n   = 1'b0;
   sdis_bus_s   bus       = '0;
   sdis_src_s   src       = '0;
   logic        ack       = 1'b0;
   logic [31:0] rdata, e, mask;
   logic        irq, nev, latched;
   int          rises, events, fail_count, n_compared;
   logic [9:0]  r;
   always #2.5 i_sys_clk = ~i_sys_clk;
   sdis_irq dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(bus.addr), .i_wdata(bus.wdata),
      .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(rdata), .i_audio_pwr_pulse(src.audio_pwr_pulse),
      .i_sideband_done_pulse(src.sideband_done_pulse), .i_digital_attach_line(src.digital_attach_line),
      .i_digital_attach_enable(src.digital_attach_enable), .i_digital_attach_detect(src.digital_attach_detect),
      .i_analog_blue_detect(src.analog_blue_detect), .i_analog_green_detect(src.analog_green_detect),
      .i_serial_bus_pulse(src.serial_bus_pulse), .o_south_irq(irq), .o_north_south_event(nev));
   sdis_north_model north_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_south_irq(irq),
      .i_north_event(nev), .i_ack(ack), .o_latched_ff(latched), .o_rise_cnt(rises), .o_event_cnt(events));
   // ***************************************
   // Bus, source and checking tasks
   // ***************************************
   // Expected bit map of the pulse sources; unused positions stay zero
   function automatic logic [31:0] ebits(logic [2:0] a, logic [2:0] s, logic [2:0] d, logic g);
      return {a, 1'b0, s, 1'b0, d, 3'b000, g, 17'h0};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, m, g, x);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_sys_clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rchk(input logic [3:0] a, input logic [31:0] x, input string m);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge i_sys_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, x, m);
   endtask
   task automatic fire(input logic [2:0] a, input logic [2:0] s, input logic [2:0] d, input logic g);
      @(posedge i_sys_clk);
      {src.audio_pwr_pulse, src.sideband_done_pulse, src.digital_attach_detect, src.serial_bus_pulse} <= {a, s, d, g};
      @(posedge i_sys_clk);
      {src.audio_pwr_pulse, src.sideband_done_pulse, src.digital_attach_detect, src.serial_bus_pulse} <= '0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ***************************************
   // Test sequence and watchdog
   // ***************************************
   // Whole sequence needs a few hundred cycles; forty thousand means a hang
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h24A078B9));
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      rchk(SDIS_ADDR_STATUS, SDIS_RST_STATUS, "status reset");
      rchk(SDIS_ADDR_MASK, SDIS_RST_MASK & SDIS_IMPL_BITS, "mask reset");
      rchk(SDIS_ADDR_IDENT, SDIS_RST_IDENT, "ident reset");
      wr(SDIS_ADDR_STATUS, 32'hFFFFFFFF);
      rchk(SDIS_ADDR_STATUS, 32'h0, "status write");
      wr(SDIS_ADDR_ENABLE, 32'hFFFFFFFF);
      rchk(SDIS_ADDR_ENABLE, SDIS_IMPL_BITS, "reserved enable");
      wr(SDIS_ADDR_ENABLE, 32'h0);
      fire(3'h7, 3'h7, 3'h7, 1'b1);
      rchk(SDIS_ADDR_IDENT, 32'h0, "masked sources");
      wr(SDIS_ADDR_MASK, 32'h0);
      // Each pulse source alone: set, survive a zero write, clear on one
      for (int i = 0; i < 10; i++) begin
         r = 10'h1 << i;
         e = ebits(r[9:7], r[6:4], r[3:1], r[0]);
         fire(r[9:7], r[6:4], r[3:1], r[0]);
         rchk(SDIS_ADDR_IDENT, e, "pulse set");
         wr(SDIS_ADDR_IDENT, ~e);
         rchk(SDIS_ADDR_IDENT, e, "zero write");
         wr(SDIS_ADDR_IDENT, e);
         rchk(SDIS_ADDR_IDENT, 32'h0, "one clears");
      end
      // Analog level and both edges, then attach levels gated by enable
      @(posedge i_sys_clk);
      src.analog_blue_detect <= 1'b1;
      settle(3);
      rchk(SDIS_ADDR_STATUS, 32'h00080000, "analog level");
      rchk(SDIS_ADDR_IDENT, 32'h00080000, "analog rise");
      wr(SDIS_ADDR_IDENT, 32'h00080000);
      src.analog_blue_detect <= 1'b0;
      settle(3);
      rchk(SDIS_ADDR_IDENT, 32'h00080000, "analog fall");
      wr(SDIS_ADDR_IDENT, 32'hFFFFFFFF);
      repeat (4) begin
         r = 10'($urandom);
         @(posedge i_sys_clk);
         src.digital_attach_line <= r[2:0];
         src.digital_attach_enable <= r[5:3];
         settle(2);
         rchk(SDIS_ADDR_STATUS, {8'h0, r[2:0] & r[5:3], 21'h0}, "attach level");
      end
      // Random bursts under a random mask; reserved places never set
      mask = $urandom;
      wr(SDIS_ADDR_MASK, mask);
      rchk(SDIS_ADDR_MASK, mask & SDIS_IMPL_BITS, "mask readback");
      // Software writes back what it read, reserved places included
      wr(SDIS_ADDR_MASK, mask & SDIS_IMPL_BITS);
      e = 32'h0;
      repeat (40) begin
         r = 10'($urandom);
         fire(r[9:7], r[6:4], r[3:1], r[0]);
         e = e | (ebits(r[9:7], r[6:4], r[3:1], r[0]) & ~mask);
      end
      rchk(SDIS_ADDR_IDENT, e, "random ident");
      // Repeated bursts leave queued copies that re-raise once, so clear twice
      wr(SDIS_ADDR_IDENT, 32'hFFFFFFFF);
      wr(SDIS_ADDR_IDENT, 32'hFFFFFFFF);
      rchk(SDIS_ADDR_IDENT, 32'h0, "queue drained");
      wr(SDIS_ADDR_MASK, 32'h0);
      // Enable waits in stage one until the arm register is written
      fire(3'h0, 3'h0, 3'h0, 1'b1);
      wr(SDIS_ADDR_ENABLE, 32'h00020000);
      settle(3);
      chk({31'h0, irq}, 32'h0, "irq before arm");
      rchk(SDIS_ADDR_ENABLE, 32'h00020000, "stage one");
      rchk(SDIS_ADDR_EN_ARM, 32'h1, "arm flag");
      wr(SDIS_ADDR_EN_ARM, 32'h0);
      settle(4);
      chk({31'h0, irq}, 32'h1, "irq after arm");
      chk(32'(events), 32'h1, "one event");
      chk({31'h0, latched}, 32'h1, "north latch");
      ack <= 1'b1;
      fire(3'h0, 3'h0, 3'h0, 1'b1);
      ack <= 1'b0;
      wr(SDIS_ADDR_IDENT, 32'h00020000);
      settle(4);
      chk({31'h0, irq}, 32'h1, "queued raise");
      chk(32'(events), 32'h2, "queued event");
      chk(32'(events), 32'(rises), "edge only");
      chk({31'h0, latched}, 32'h1, "north relatch");
      wr(SDIS_ADDR_IDENT, 32'h00020000);
      settle(3);
      chk({31'h0, irq}, 32'h0, "all cleared");
      fire(3'h4, 3'h0, 3'h0, 1'b0);
      rchk(SDIS_ADDR_IDENT, 32'h80000000, "disabled polls");
      chk({31'h0, irq}, 32'h0, "disabled quiet");
      summarize();
   end
endmodule
